// *** ufb_core.sv ***
// One UART channel: baud settings, frame format, shifters.
// Assumes an APB master on CORE_CLK and an asynchronous RXD line.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ufb_core import ufb_pkg::*; (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RXD,
    output logic TXD
);
    logic [18:0] div_r;
    logic [15:0] txpat_r;
    logic [15:0] rxpat_r;
    logic [7:0] fmt_r;
    logic [31:0] rdata_nxt;
    logic hit_nxt;
    logic [7:0] idx;
    logic setup;
    logic acc;
    logic wr;
    logic rd;
    // ==========================================================
    // APB decode; no wait state, read data comes from a flop loaded in the setup cycle
    assign idx = PADDR[ADDR_W+BYTE_SHIFT-1:BYTE_SHIFT];
    assign setup = PSEL && !PENABLE;
    assign acc = PSEL && PENABLE && PREADY;
    assign wr = acc && PWRITE && !PSLVERR;
    assign rd = acc && !PWRITE && !PSLVERR;

    // ==========================================================
    // Frame format decode
    logic [3:0] dbits;
    logic [2:0] pmode;
    logic par_en;
    logic two_stop;
    // Reserved word-length codes fall back to eight bits
    assign dbits = (fmt_r[3:0] == DBITS_7 || fmt_r[3:0] == DBITS_9) ? fmt_r[3:0] : DBITS_8;
    assign pmode = fmt_r[FMT_PAR_LSB+2:FMT_PAR_LSB];
    assign par_en = (pmode != PAR_NONE) && (pmode <= PAR_SPACE) && (dbits != DBITS_9);
    assign two_stop = fmt_r[FMT_STOP_BIT];

    function automatic logic par_of(input logic [8:0] d, input logic [3:0] n, input logic [2:0] m);
        logic [8:0] msk;
        logic x;
        msk = (n == DBITS_7) ? 9'h07f : 9'h0ff;
        x = ^(d & msk);
        case (m)
            PAR_ODD: par_of = ~x;
            PAR_EVEN: par_of = x;
            PAR_MARK: par_of = 1'b1;
            default: par_of = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Transmitter
    ufb_ser_t tx_st_r;
    logic [8:0] tx_sh_r;
    logic [3:0] tx_cnt_r;
    logic tx_par_r;
    logic tx_run_r;
    logic tx_tick;
    ufb_baud_gen u_tx_baud (
        .clk(CORE_CLK), .rst_n(RESETN), .ce(CE), .run(tx_run_r),
        .divisor(div_r), .pattern(txpat_r), .mid(), .tick(tx_tick)
    );
    logic tx_go;
    assign tx_go = wr && (idx == IDX_TX_DATA) && (tx_st_r == SER_IDLE);

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_st_r <= SER_IDLE;
            tx_sh_r <= 9'h0;
            tx_cnt_r <= 4'h0;
            tx_par_r <= 1'b0;
            tx_run_r <= 1'b0;
            TXD <= 1'b1;
        end else if (CE) begin
            if (tx_go) begin
                tx_sh_r <= PWDATA[8:0];
                tx_par_r <= par_of(PWDATA[8:0], dbits, pmode);
                tx_st_r <= SER_START;
                tx_run_r <= 1'b1;
                TXD <= 1'b0;
            end else if (tx_tick) begin
                case (tx_st_r)
                    SER_START: begin
                        tx_st_r <= SER_DATA;
                        TXD <= tx_sh_r[0];
                        tx_sh_r <= tx_sh_r >> 1;
                        tx_cnt_r <= 4'h1;
                    end
                    SER_DATA: begin
                        if (tx_cnt_r == dbits) begin
                            tx_st_r <= par_en ? SER_PARITY : SER_STOP;
                            TXD <= par_en ? tx_par_r : 1'b1;
                        end else begin
                            TXD <= tx_sh_r[0];
                            tx_sh_r <= tx_sh_r >> 1;
                            tx_cnt_r <= tx_cnt_r + 4'h1;
                        end
                    end
                    SER_PARITY: begin
                        tx_st_r <= SER_STOP;
                        TXD <= 1'b1;
                    end
                    SER_STOP: begin
                        tx_st_r <= two_stop ? SER_STOP2 : SER_IDLE;
                        tx_run_r <= two_stop;
                    end
                    default: begin
                        tx_st_r <= SER_IDLE;
                        tx_run_r <= 1'b0;
                        TXD <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Receiver; samples each bit at its middle
    logic rxd_m_r;
    logic rxd_s_r;
    ufb_ser_t rx_st_r;
    logic [8:0] rx_sh_r;
    logic [3:0] rx_cnt_r;
    logic rx_run_r;
    logic [8:0] rx_data_r;
    logic rx_valid_r;
    logic perr_r;
    logic ferr_r;
    logic rx_mid;
    logic [8:0] rx_word;
    ufb_baud_gen u_rx_baud (
        .clk(CORE_CLK), .rst_n(RESETN), .ce(CE), .run(rx_run_r),
        .divisor(div_r), .pattern(rxpat_r), .mid(rx_mid), .tick()
    );
    assign rx_word = rx_sh_r >> (4'h9 - dbits);
    logic perr_set;
    logic ferr_set;
    logic rx_done;
    assign perr_set = rx_mid && (rx_st_r == SER_PARITY) && (rxd_s_r != par_of(rx_word, dbits, pmode));
    assign ferr_set = rx_mid && ((rx_st_r == SER_STOP) || (rx_st_r == SER_STOP2)) && !rxd_s_r;
    assign rx_done = rx_mid && (rx_st_r == SER_STOP);
    logic st_rd;
    assign st_rd = rd && (idx == IDX_STATUS);

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rxd_m_r <= 1'b1;
            rxd_s_r <= 1'b1;
            rx_st_r <= SER_IDLE;
            rx_sh_r <= 9'h0;
            rx_cnt_r <= 4'h0;
            rx_run_r <= 1'b0;
            rx_data_r <= 9'h0;
            rx_valid_r <= 1'b0;
            perr_r <= 1'b0;
            ferr_r <= 1'b0;
        end else if (CE) begin
            rxd_m_r <= RXD;
            rxd_s_r <= rxd_m_r;
            // Set wins over the clearing read
            perr_r <= perr_set || (perr_r && !st_rd);
            ferr_r <= ferr_set || (ferr_r && !st_rd);
            rx_valid_r <= rx_done || (rx_valid_r && !(rd && idx == IDX_RX_DATA));
            if (rx_done) begin
                rx_data_r <= rx_word;
            end
            if (rx_st_r == SER_IDLE) begin
                if (!rxd_s_r) begin
                    rx_st_r <= SER_START;
                    rx_run_r <= 1'b1;
                end
            end else if (rx_mid) begin
                case (rx_st_r)
                    SER_START: begin
                        // Glitch shorter than half a bit is dropped
                        rx_st_r <= rxd_s_r ? SER_IDLE : SER_DATA;
                        rx_run_r <= !rxd_s_r;
                        rx_cnt_r <= 4'h0;
                    end
                    SER_DATA: begin
                        rx_sh_r <= {rxd_s_r, rx_sh_r[8:1]};
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_cnt_r + 4'h1 == dbits) begin
                            rx_st_r <= par_en ? SER_PARITY : SER_STOP;
                        end
                    end
                    SER_PARITY: rx_st_r <= SER_STOP;
                    SER_STOP: begin
                        rx_st_r <= two_stop ? SER_STOP2 : SER_IDLE;
                        rx_run_r <= two_stop;
                    end
                    default: begin
                        rx_st_r <= SER_IDLE;
                        rx_run_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Register read mux
    always_comb begin
        rdata_nxt = 32'h0;
        hit_nxt = 1'b1;
        if (idx == IDX_DIV_LOW) begin
            rdata_nxt[7:0] = div_r[7:0];
        end else if (idx == IDX_DIV_MID) begin
            rdata_nxt[7:0] = div_r[15:8];
        end else if (idx == IDX_DIV_TOP) begin
            rdata_nxt[2:0] = div_r[18:16];
        end else if (idx == IDX_TXPAT_LOW) begin
            rdata_nxt[7:0] = txpat_r[7:0];
        end else if (idx == IDX_TXPAT_HIGH) begin
            rdata_nxt[7:0] = txpat_r[15:8];
        end else if (idx == IDX_RXPAT_LOW) begin
            rdata_nxt[7:0] = rxpat_r[7:0];
        end else if (idx == IDX_RXPAT_HIGH) begin
            rdata_nxt[7:0] = rxpat_r[15:8];
        end else if (idx == IDX_FORMAT) begin
            rdata_nxt[7:0] = fmt_r;
        end else if (idx == IDX_TX_DATA) begin
            rdata_nxt = 32'h0;
        end else if (idx == IDX_RX_DATA) begin
            rdata_nxt[8:0] = rx_data_r;
        end else if (idx == IDX_STATUS) begin
            rdata_nxt[ST_TX_BUSY] = (tx_st_r != SER_IDLE);
            rdata_nxt[ST_RX_VALID] = rx_valid_r;
            rdata_nxt[ST_PAR_ERR] = perr_r;
            rdata_nxt[ST_FRM_ERR] = ferr_r;
        end else begin
            hit_nxt = 1'b0;
        end
        if (PADDR[31:ADDR_W+BYTE_SHIFT] != 22'h0 || PADDR[BYTE_SHIFT-1:0] != 2'h0) begin
            hit_nxt = 1'b0;
        end
    end

    // ==========================================================
    // Bus response and configuration registers
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0;
            div_r <= 19'h0;
            txpat_r <= 16'h0;
            rxpat_r <= 16'h0;
            fmt_r <= RST_BYTE;
        end else if (CE) begin
            PREADY <= setup;
            PSLVERR <= setup && !hit_nxt;
            if (setup) begin
                PRDATA <= hit_nxt ? rdata_nxt : 32'h0;
            end
            if (wr) begin
                if (idx == IDX_DIV_LOW) begin
                    div_r[7:0] <= PWDATA[7:0];
                end else if (idx == IDX_DIV_MID) begin
                    div_r[15:8] <= PWDATA[7:0];
                end else if (idx == IDX_DIV_TOP) begin
                    div_r[18:16] <= PWDATA[2:0];
                end else if (idx == IDX_TXPAT_LOW) begin
                    txpat_r[7:0] <= PWDATA[7:0];
                end else if (idx == IDX_TXPAT_HIGH) begin
                    txpat_r[15:8] <= PWDATA[7:0];
                end else if (idx == IDX_RXPAT_LOW) begin
                    rxpat_r[7:0] <= PWDATA[7:0];
                end else if (idx == IDX_RXPAT_HIGH) begin
                    rxpat_r[15:8] <= PWDATA[7:0];
                end else if (idx == IDX_FORMAT) begin
                    fmt_r <= PWDATA[7:0];
                end
            end
        end
    end
endmodule // ufb_core
`default_nettype wire

// *** ufb_pkg.sv ***
// Constants for the fractional baud and frame format core.
// Assumes a 32-bit APB register bus with word-aligned registers.
package ufb_pkg;
    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DIV_LOW = 8'h04;
    localparam logic [7:0] IDX_DIV_MID = 8'h05;
    localparam logic [7:0] IDX_DIV_TOP = 8'h06;
    localparam logic [7:0] IDX_TXPAT_LOW = 8'h07;
    localparam logic [7:0] IDX_TXPAT_HIGH = 8'h08;
    localparam logic [7:0] IDX_RXPAT_LOW = 8'h09;
    localparam logic [7:0] IDX_RXPAT_HIGH = 8'h0a;
    localparam logic [7:0] IDX_FORMAT = 8'h0b;
    localparam logic [7:0] IDX_TX_DATA = 8'h20;
    localparam logic [7:0] IDX_RX_DATA = 8'h21;
    localparam logic [7:0] IDX_STATUS = 8'h22;
    localparam int ADDR_W = 8;
    localparam int BYTE_SHIFT = 2;
    // ==========================================================
    // Field positions and reset values
    localparam int FMT_STOP_BIT = 7;
    localparam int FMT_PAR_LSB = 4;
    localparam logic [3:0] DBITS_7 = 4'h7;
    localparam logic [3:0] DBITS_8 = 4'h8;
    localparam logic [3:0] DBITS_9 = 4'h9;
    localparam logic [2:0] PAR_NONE = 3'h0;
    localparam logic [2:0] PAR_ODD = 3'h1;
    localparam logic [2:0] PAR_EVEN = 3'h2;
    localparam logic [2:0] PAR_MARK = 3'h3;
    localparam logic [2:0] PAR_SPACE = 3'h4;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int ST_TX_BUSY = 0;
    localparam int ST_RX_VALID = 1;
    localparam int ST_PAR_ERR = 2;
    localparam int ST_FRM_ERR = 3;
    // ==========================================================
    // Serial state, Gray coded along the normal path
    typedef enum logic [2:0] {
        SER_IDLE = 3'h0,
        SER_START = 3'h1,
        SER_DATA = 3'h3,
        SER_PARITY = 3'h2,
        SER_STOP = 3'h6,
        SER_STOP2 = 3'h7
    } ufb_ser_t;
endpackage

// *** ufb_baud_gen.sv ***
// Fractional bit-period timer.
// Assumes divisor and pattern are held steady while running.
`timescale 1ns/1ps
`default_nettype none
module ufb_baud_gen import ufb_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic run,
    input wire logic [18:0] divisor,
    input wire logic [15:0] pattern,
    output logic mid,
    output logic tick
);
    logic [19:0] cnt_r;
    logic [3:0] idx_r;
    logic [19:0] len_raw;
    logic [19:0] len;
    logic last;
    // ==========================================================
    // Period length: divisor plus one where pattern bit set
    assign len_raw = {1'b0, divisor} + {19'h0, pattern[idx_r]};
    // Zero divisor would stretch a bit to 2^20 cycles, until the 20-bit counter wraps
    assign len = (len_raw == 20'h0) ? 20'h1 : len_raw;
    assign last = (cnt_r == len - 20'h1);
    // Unregistered, else the first bit would run one cycle long
    assign tick = run && last;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 20'h0;
            idx_r <= 4'h0;
            mid <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt_r <= 20'h0;
                idx_r <= 4'h0;
                mid <= 1'b0;
            end else begin
                mid <= (cnt_r == {1'b0, len[19:1]});
                cnt_r <= last ? 20'h0 : cnt_r + 20'h1;
                idx_r <= last ? idx_r + 4'h1 : idx_r;
            end
        end
    end
endmodule // ufb_baud_gen
`default_nettype wire

// *** ufb_core_chk.sv ***
// Port-level checks for the baud and frame format core.
// Assumes it is bound into ufb_core; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ufb_core_chk (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic RXD,
    input wire logic TXD
);
    // ==========================================
    // Shadows of accepted writes
    logic [7:0] lo_r;
    logic [7:0] hi_r;
    logic sent_r;
    wire logic wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    wire logic [7:0] lo_nxt = (wr_ok && PADDR == 32'h24) ? PWDATA[7:0] : lo_r;
    wire logic [7:0] hi_nxt = (wr_ok && PADDR == 32'h28) ? PWDATA[7:0] : hi_r;
    wire logic sent_nxt = sent_r || (wr_ok && PADDR == 32'h80);
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            lo_r <= 8'h00;
            hi_r <= 8'h00;
            sent_r <= 1'b0;
        end else begin
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            sent_r <= sent_nxt;
        end
    end
    // ==========================================
    // Bus timing, refusals and read-back
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    setup_answer_a: assert property (CE && PSEL && !PENABLE |=> PREADY)
        else $error("no answer after setup");
    one_cycle_a: assert property (PREADY |=> !PREADY)
        else $error("answer held too long");
    idle_quiet_a: assert property (!PSEL |=> !PREADY)
        else $error("answer without request");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error outside access");
    unmapped_err_a: assert property (PREADY && PADDR == 32'h30 |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access accepted");
    misalign_err_a: assert property (PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR)
        else $error("misaligned access accepted");
    rx_low_read_a: assert property (PREADY && !PWRITE && PADDR == 32'h24 |-> !PSLVERR && PRDATA == {24'h0, lo_r})
        else $error("pattern low read wrong");
    rx_high_read_a: assert property (PREADY && !PWRITE && PADDR == 32'h28 |-> !PSLVERR && PRDATA == {24'h0, hi_r})
        else $error("pattern high read wrong");
    format_ok_a: assert property (PREADY && PADDR == 32'h2c |-> !PSLVERR)
        else $error("format access refused");
    txd_idle_a: assert property (!sent_r |-> TXD)
        else $error("line left idle level");
    cover property (wr_ok && PADDR == 32'h80);
    cover property (PREADY && PSLVERR);
    cover property (PREADY && !PWRITE && PADDR == 32'h84);
endmodule // ufb_core_chk
bind ufb_core ufb_core_chk u_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD));
`default_nettype wire

// *** ufb_core_test.sv ***
// Self-checking bench for the baud and frame format core.
// Assumes ufb_core with APB registers; bench drives the serial input.
`timescale 1ns/1ps
`default_nettype none
module ufb_core_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic rxd = 1'b1;
    logic ce = 1'b1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic txd;
    logic [31:0] rd;
    logic slv;
    int n;
    int err_total = 0;
    int checked = 0;
    logic [7:0] fmts [7] = '{8'h17, 8'h28, 8'hb8, 8'h48, 8'h19, 8'h08, 8'h53};
    always #20 clk = ~clk;
    ufb_core DUT (.CORE_CLK(clk), .RESETN(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .RXD(rxd), .TXD(txd));
    // ==========================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Request held until pready is seen at an edge; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    // Expected line bits, start first, stops padded as ones
    function automatic void build(input logic [7:0] f, input logic [8:0] d, output logic [15:0] b, output int nb);
        int nd;
        logic pe;
        logic [8:0] m;
        nd = (f[3:0] == 4'h7) ? 7 : (f[3:0] == 4'h9) ? 9 : 8;
        pe = (nd != 9) && (f[6:4] >= 3'h1) && (f[6:4] <= 3'h4);
        m = 9'h1ff >> (9 - nd);
        b = 16'hffff;
        b[0] = 1'b0;
        for (int j = 0; j < nd; j++) b[1 + j] = d[j];
        if (pe) b[1 + nd] = (f[6:4] == 3'h1) ? ~^(d & m) : (f[6:4] == 3'h2) ? ^(d & m) : (f[6:4] == 3'h3);
        nb = 2 + nd + int'(pe) + int'(f[7]);
    endfunction
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            apb(1'b0, 32'h88, 32'h0);
            k++;
        end while (rd[0] !== 1'b0 && k < 40);
        check({31'h0, rd[0]}, 32'h0);
    endtask
    // Sample each bit one and a half clock cycles in, clear of both edges
    task automatic tx_frame(input logic [7:0] fmt, input logic [8:0] d);
        logic [15:0] b;
        int nb;
        build(fmt, d, b, nb);
        wr(32'h2c, {24'h0, fmt});
        if (fmt[3:0] != 4'h9) rdc(32'h2c, {24'h0, fmt});
        wr(32'h80, {23'h0, d});
        repeat (2) @(negedge clk);
        for (int j = 0; j < nb; j++) begin
            check({31'h0, txd}, {31'h0, b[j]});
            repeat (4) @(negedge clk);
        end
        wait_idle();
    endtask
    task automatic rx_frame(input logic [7:0] fmt, input logic [8:0] d, input logic [15:0] flip);
        logic [15:0] b;
        int nb;
        build(fmt, d, b, nb);
        b = b ^ flip;
        for (int j = 0; j < nb; j++) begin
            @(posedge clk);
            rxd <= b[j];
            repeat (15) @(posedge clk);
        end
        @(posedge clk);
        rxd <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic run_len(input logic lvl);
        n = 0;
        while (txd === lvl && n < 40) begin
            n++;
            @(negedge clk);
        end
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rdc(32'h24, 32'h0);
        rdc(32'h28, 32'h0);
        rdc(32'h2c, 32'h0);
        wr(32'h24, 32'hffffff6a);
        rdc(32'h24, 32'h6a);
        wr(32'h28, 32'h0b);
        rdc(32'h28, 32'h0b);
        apb(1'b0, 32'h30, 32'h0);
        check({31'h0, slv}, 32'h1);
        check(rd, 32'h0);
        wr(32'h25, 32'h55);
        check({31'h0, slv}, 32'h1);
        rdc(32'h24, 32'h6a);
        // Listed rate pair: divisor 416 split over three bytes
        wr(32'h10, 32'ha0);
        wr(32'h14, 32'h01);
        wr(32'h18, 32'h00);
        wr(32'h1c, 32'h6d);
        wr(32'h20, 32'h0b);
        wr(32'h28, 32'h0b);
        rdc(32'h10, 32'ha0);
        rdc(32'h14, 32'h01);
        rdc(32'h18, 32'h00);
        rdc(32'h1c, 32'h6d);
        rdc(32'h20, 32'h0b);
        rdc(32'h28, 32'h0b);
        // Unlisted rate at fraction index 31, odd divisor column
        wr(32'h10, 32'h0f);
        wr(32'h1c, 32'hff);
        wr(32'h20, 32'h0f);
        wr(32'h24, 32'hfd);
        wr(32'h28, 32'h0f);
        rdc(32'h1c, 32'hff);
        rdc(32'h20, 32'h0f);
        rdc(32'h24, 32'hfd);
        rdc(32'h28, 32'h0f);
        rdc(32'h80, 32'h0);
        wr(32'h1c, 32'h0);
        wr(32'h20, 32'h0);
        wr(32'h24, 32'h0);
        wr(32'h28, 32'h0);
        wr(32'h10, 32'h4);
        wr(32'h14, 32'h0);
        wr(32'h18, 32'h0);
        for (int j = 0; j < 7; j++) begin
            tx_frame(fmts[j], 9'h1a5);
        end
        // Only pattern bit 0 set, so only the start bit stretches
        wr(32'h1c, 32'h1);
        wr(32'h2c, 32'h08);
        wr(32'h80, 32'h1);
        @(negedge clk);
        run_len(1'b0);
        check(32'(n), 32'h5);
        run_len(1'b1);
        check(32'(n), 32'h4);
        wait_idle();
        wr(32'h1c, 32'h0);
        // Frozen enable stretches the start bit by the frozen span
        wr(32'h80, 32'h1);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        @(negedge clk);
        run_len(1'b0);
        check(32'(n), 32'h4);
        run_len(1'b1);
        check(32'(n), 32'h4);
        wait_idle();
        // Receive needs a longer bit to clear sync latency
        wr(32'h10, 32'h10);
        wr(32'h2c, 32'h28);
        rx_frame(8'h28, 9'h0c3, 16'h0);
        rdc(32'h88, 32'h2);
        rdc(32'h84, 32'hc3);
        rx_frame(8'h28, 9'h05a, 16'h0200);
        rdc(32'h88, 32'h6);
        rdc(32'h84, 32'h5a);
        wr(32'h2c, 32'hb8);
        rx_frame(8'hb8, 9'h0ff, 16'h0400);
        rdc(32'h88, 32'ha);
        rdc(32'h88, 32'h2);
        rdc(32'h84, 32'hff);
        end_of_test();
    end
    // Run needs under two thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_of_test();
    end
endmodule // ufb_core_test
`default_nettype wire
